// *** logic/dac_port_pkg.sv ***
// Shared constants and types of the dual DAC serial command port
package dac_port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam logic [5:0] LAST_BIT_COUNT = 6'h1f;
  localparam int         CMD_MSB        = 27;
  localparam int         CMD_LSB        = 24;
  localparam int         ADDR_MSB       = 23;
  localparam int         ADDR_LSB       = 20;
  localparam int         DATA_MSB       = 19;
  localparam int         DATA_LSB       = 4;
  localparam int         PD_MODE_HI     = 9;
  localparam int         PD_MODE_LO     = 8;
  localparam int         FRAME_BIT_1    = 1;
  localparam int         FRAME_BIT_0    = 0;
  localparam int         CODE_MSB       = 15;
  localparam int         SEG_LSB        = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Commands and channel addresses
  localparam logic [3:0] CMD_WRITE_INPUT      = 4'h0;
  localparam logic [3:0] CMD_UPDATE_DAC       = 4'h1;
  localparam logic [3:0] CMD_WRITE_UPDATE_ALL = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPDATE     = 4'h3;
  localparam logic [3:0] CMD_POWER            = 4'h4;
  localparam logic [3:0] CMD_CLEAR_CODE       = 4'h5;
  localparam logic [3:0] CMD_UPDATE_MASK      = 4'h6;
  localparam logic [3:0] CMD_SOFT_RESET       = 4'h7;
  localparam logic [3:0] CMD_CHAIN            = 4'h8;
  localparam logic [3:0] CMD_DIO              = 4'h9;
  localparam logic [3:0] CMD_RESERVED         = 4'hf;
  localparam logic [3:0] ADDR_CH_A            = 4'h0;
  localparam logic [3:0] ADDR_CH_B            = 4'h1;
  localparam logic [3:0] ADDR_ALL             = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [15:0] CODE_RESET   = 16'h0000;
  localparam logic [1:0]  PD_RESET     = 2'h0;
  localparam logic [1:0]  CLEAR_RESET  = 2'h0;
  localparam logic [1:0]  MASK_RESET   = 2'h0;
  localparam logic        CHAIN_RESET  = 1'b0;
  localparam logic        ENABLE_RESET = 1'b1;
  localparam logic [7:0]  COUNT_RESET  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Bus register offsets and control bits
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INPUT  = 8'h08;
  localparam logic [7:0] REG_DAC    = 8'h0c;
  localparam int         CTRL_SOFT_UPDATE  = 0;
  localparam int         CTRL_FRAME_ENABLE = 1;

  typedef enum logic [1:0] {FR_IDLE, FR_SHIFT, FR_HOLD} frame_state_t;

endpackage

// *** logic/sync_edge.sv ***
// Two-flop synchroniser with edge detection on the stable stage
`timescale 1ns/100ps
module sync_edge (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta;
  logic stable;
  logic prev;
  logic next_meta;
  logic next_stable;
  logic next_prev;

  always_comb begin
    next_meta   = async_i;
    next_stable = meta;
    next_prev   = stable;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      prev   <= 1'b0;
    end else begin
      meta   <= next_meta;
      stable <= next_stable;
      prev   <= next_prev;
    end
  end

  assign level_o = stable;
  assign rise_o  = stable & ~prev;
  assign fall_o  = ~stable & prev;
endmodule

// *** logic/dual_dac_serial_command_port.sv ***
// Serial frame receiver, command decoder and register file of a dual DAC
// Behaviour
// [RULE1] Shift data in on each serial clock fall
// [RULE2] Execute frame at the 32nd falling edge
// [RULE3] Host holds frame sync high 15 ns minimum
// [RULE4] Host may park frame sync low between frames
// [RULE5] Ignored nibble, command, address, then data
// [RULE6] Data word MSB first, padded to 32
// [RULE7] Code 0 writes input, 1 updates DAC
// [RULE8] Code 2 writes input, updates all DACs
// [RULE9] Code 3 writes and updates one channel
// [RULE10] Codes 4-7: power, clear, mask, reset
// [RULE11] Code 8 chain, 9 digital IO, 15 reserved
// [RULE12] Address 0 A, 1 B, 15 both
// [RULE13] Early frame sync rise discards the frame
// [RULE14] Chain setup takes frame bit 1
// [RULE15] Chain enable clears at reset
// [RULE16] Chain mode shifts older bits to serial out
// [RULE17] Host gives exactly 32N clocks per chain
// [RULE18] Frame sync rise stops shifting
// [RULE19] Gated clock: exact burst then raise sync
// [RULE20] Free clock only with exact sync timing
// [RULE21] DAC codes are straight binary
// [RULE22] Top nibble thermometer, low 12 to ladder
// [RULE23] Power command bits 9:8 pick mode
// [RULE24] Power command bits 1:0 pick channels
// [RULE25] Reserved command or address changes nothing; codes 4 to 9 ignore the address and act on any address
// [RULE26] Standalone: quiet output, extra clocks ignored
`timescale 1ns/100ps
module dual_dac_serial_command_port
  import dac_port_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        sclk_i,
  input  wire logic        sync_n_i,
  input  wire logic        din_i,
  input  wire logic        digital_io_i,
  output logic             serial_out_o,
  output logic             digital_io_o,
  output logic             digital_io_oe_o,
  output logic [15:0]      dac_a_o,
  output logic [15:0]      dac_b_o,
  output logic [14:0]      seg_a_o,
  output logic [14:0]      seg_b_o,
  output logic [11:0]      ladder_a_o,
  output logic [11:0]      ladder_b_o,
  output logic [1:0]       pd_mode_a_o,
  output logic [1:0]       pd_mode_b_o,
  output logic [1:0]       clear_code_o,
  output logic [1:0]       update_mask_o,
  output logic             chain_enable_o,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic sclk_rise;
  logic sclk_fall;
  logic sync_rise;
  logic sync_fall;
  logic din_s;
  logic dio_s;

  sync_edge u_sclk (.clk_i(clk_i), .rst_i(rst_i), .async_i(sclk_i),
                    .level_o(), .rise_o(sclk_rise), .fall_o(sclk_fall));
  sync_edge u_sync (.clk_i(clk_i), .rst_i(rst_i), .async_i(sync_n_i),
                    .level_o(), .rise_o(sync_rise), .fall_o(sync_fall));
  sync_edge u_din  (.clk_i(clk_i), .rst_i(rst_i), .async_i(din_i),
                    .level_o(din_s), .rise_o(), .fall_o());
  sync_edge u_dio  (.clk_i(clk_i), .rst_i(rst_i), .async_i(digital_io_i),
                    .level_o(dio_s), .rise_o(), .fall_o());

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  frame_state_t state;
  frame_state_t next_state;
  logic [31:0]  shift;
  logic [31:0]  next_shift;
  logic [5:0]   count;
  logic [5:0]   next_count;
  logic         full;
  logic         next_full;
  logic         serial_out;
  logic         next_serial_out;
  logic         exec_now;
  logic         discard_now;
  logic [31:0]  exec_word;
  logic [15:0]  input_a, input_b, dac_a, dac_b;
  logic [15:0]  next_input_a, next_input_b, next_dac_a, next_dac_b;
  logic [1:0]   pd_mode_a, pd_mode_b, clear_code, update_mask;
  logic [1:0]   next_pd_mode_a, next_pd_mode_b, next_clear_code, next_update_mask;
  logic         chain_enable, dio_dir, dio_value;
  logic         next_chain_enable, next_dio_dir, next_dio_value;
  logic [7:0]   done_count, drop_count, next_done_count, next_drop_count;
  logic         frame_enable, soft_update, ack;
  logic         next_frame_enable, next_soft_update, next_ack;
  logic [31:0]  rdata, next_rdata;
  logic [14:0]  seg_a, seg_b, next_seg_a, next_seg_b;
  logic [11:0]  ladder_a, ladder_b, next_ladder_a, next_ladder_b;
  logic [3:0]   cmd;
  logic [3:0]   addr;
  logic [15:0]  frame_data;
  logic         sel_a;
  logic         sel_b;
  logic         addr_ok;

  function automatic logic [14:0] therm(input logic [3:0] msb);
    return 15'((16'h0001 << msb) - 16'h0001);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine
  always_comb begin
    next_state      = state;
    next_shift      = shift;
    next_count      = count;
    next_full       = full;
    next_serial_out = serial_out;
    exec_now        = 1'b0;
    discard_now     = 1'b0;
    exec_word       = shift;
    case (state)
      FR_IDLE: begin
        if (sync_fall && frame_enable) begin
          next_state = FR_SHIFT;
          next_shift = 32'h0000_0000;
          next_count = 6'h00;
          next_full  = 1'b0;
        end
      end
      FR_SHIFT: begin
        if (sync_rise) begin // [RULE18]
          if (chain_enable && full) begin
            exec_now = 1'b1;
          end else begin
            discard_now = 1'b1; // [RULE13]
          end
          next_shift = 32'h0000_0000; // [RULE13]
          next_count = 6'h00;
          next_full  = 1'b0;
          next_state = FR_IDLE;
        end else if (sclk_fall) begin
          next_shift = {shift[30:0], din_s}; // [RULE1]
          if (count == LAST_BIT_COUNT) begin
            next_full = 1'b1;
            if (!chain_enable) begin
              exec_now   = 1'b1; // [RULE2]
              exec_word  = next_shift;
              next_state = FR_HOLD; // [RULE26]
            end
          end else begin
            next_count = 6'(count + 6'h01);
          end
        end else if (sclk_rise) begin
          next_serial_out = shift[31]; // [RULE16]
        end
      end
      FR_HOLD: begin
        if (sync_rise) begin
          next_state = FR_IDLE;
          next_shift = 32'h0000_0000;
          next_count = 6'h00;
          next_full  = 1'b0;
        end
      end
      default: next_state = FR_IDLE;
    endcase
    if (!chain_enable) begin
      next_serial_out = 1'b0; // [RULE26]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state      <= FR_IDLE;
      shift      <= 32'h0000_0000;
      count      <= 6'h00;
      full       <= 1'b0;
      serial_out <= 1'b0;
    end else begin
      state      <= next_state;
      shift      <= next_shift;
      count      <= next_count;
      full       <= next_full;
      serial_out <= next_serial_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and device registers
  assign cmd        = exec_word[CMD_MSB:CMD_LSB]; // [RULE5]
  assign addr       = exec_word[ADDR_MSB:ADDR_LSB]; // [RULE5]
  assign frame_data = exec_word[DATA_MSB:DATA_LSB]; // [RULE6] [RULE21]
  assign sel_a      = (addr == ADDR_CH_A) || (addr == ADDR_ALL); // [RULE12]
  assign sel_b      = (addr == ADDR_CH_B) || (addr == ADDR_ALL); // [RULE12]
  assign addr_ok    = sel_a || sel_b;

  always_comb begin
    next_input_a      = input_a;
    next_input_b      = input_b;
    next_dac_a        = dac_a;
    next_dac_b        = dac_b;
    next_pd_mode_a    = pd_mode_a;
    next_pd_mode_b    = pd_mode_b;
    next_clear_code   = clear_code;
    next_update_mask  = update_mask;
    next_chain_enable = chain_enable;
    next_dio_dir      = dio_dir;
    next_dio_value    = dio_value;
    next_done_count   = exec_now ? 8'(done_count + 8'h01) : done_count;
    next_drop_count   = discard_now ? 8'(drop_count + 8'h01) : drop_count;
    if (soft_update) begin
      if (update_mask[FRAME_BIT_0]) next_dac_a = input_a;
      if (update_mask[FRAME_BIT_1]) next_dac_b = input_b;
    end
    if (exec_now) begin
      case (cmd)
        CMD_WRITE_INPUT: begin // [RULE7]
          if (sel_a) next_input_a = frame_data;
          if (sel_b) next_input_b = frame_data;
        end
        CMD_UPDATE_DAC: begin // [RULE7]
          if (sel_a) next_dac_a = input_a;
          if (sel_b) next_dac_b = input_b;
        end
        CMD_WRITE_UPDATE_ALL: begin // [RULE8]
          if (addr_ok) begin
            if (sel_a) next_input_a = frame_data;
            if (sel_b) next_input_b = frame_data;
            next_dac_a = next_input_a;
            next_dac_b = next_input_b;
          end
        end
        CMD_WRITE_UPDATE: begin // [RULE9]
          if (sel_a) begin
            next_input_a = frame_data;
            next_dac_a   = frame_data;
          end
          if (sel_b) begin
            next_input_b = frame_data;
            next_dac_b   = frame_data;
          end
        end
        CMD_POWER: begin // [RULE10] [RULE23] [RULE24]
          if (exec_word[FRAME_BIT_0]) next_pd_mode_a = exec_word[PD_MODE_HI:PD_MODE_LO];
          if (exec_word[FRAME_BIT_1]) next_pd_mode_b = exec_word[PD_MODE_HI:PD_MODE_LO];
        end
        CMD_CLEAR_CODE:  next_clear_code = exec_word[FRAME_BIT_1:FRAME_BIT_0]; // [RULE10]
        CMD_UPDATE_MASK: next_update_mask = exec_word[FRAME_BIT_1:FRAME_BIT_0]; // [RULE10]
        CMD_SOFT_RESET: begin // [RULE10]
          next_input_a      = CODE_RESET;
          next_input_b      = CODE_RESET;
          next_dac_a        = CODE_RESET;
          next_dac_b        = CODE_RESET;
          next_pd_mode_a    = PD_RESET;
          next_pd_mode_b    = PD_RESET;
          next_clear_code   = CLEAR_RESET;
          next_update_mask  = MASK_RESET;
          next_chain_enable = CHAIN_RESET;
        end
        CMD_CHAIN: next_chain_enable = exec_word[FRAME_BIT_1]; // [RULE11] [RULE14]
        CMD_DIO: begin // [RULE11]
          next_dio_dir   = exec_word[FRAME_BIT_1];
          next_dio_value = exec_word[FRAME_BIT_0];
        end
        default: ; // [RULE11] [RULE25]
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      input_a      <= CODE_RESET;
      input_b      <= CODE_RESET;
      dac_a        <= CODE_RESET;
      dac_b        <= CODE_RESET;
      pd_mode_a    <= PD_RESET;
      pd_mode_b    <= PD_RESET;
      clear_code   <= CLEAR_RESET;
      update_mask  <= MASK_RESET;
      chain_enable <= CHAIN_RESET; // [RULE15]
      dio_dir      <= 1'b0;
      dio_value    <= 1'b0;
      done_count   <= COUNT_RESET;
      drop_count   <= COUNT_RESET;
    end else begin
      input_a      <= next_input_a;
      input_b      <= next_input_b;
      dac_a        <= next_dac_a;
      dac_b        <= next_dac_b;
      pd_mode_a    <= next_pd_mode_a;
      pd_mode_b    <= next_pd_mode_b;
      clear_code   <= next_clear_code;
      update_mask  <= next_update_mask;
      chain_enable <= next_chain_enable;
      dio_dir      <= next_dio_dir;
      dio_value    <= next_dio_value;
      done_count   <= next_done_count;
      drop_count   <= next_drop_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave
  always_comb begin
    next_ack          = wb_cyc_i & wb_stb_i & ~ack;
    next_rdata        = rdata;
    next_frame_enable = frame_enable;
    next_soft_update  = 1'b0;
    if (next_ack) begin
      case (wb_adr_i)
        REG_CTRL:   next_rdata = {30'h0000_0000, frame_enable, 1'b0};
        REG_STATUS: next_rdata = {drop_count, done_count, 3'h0, (state != FR_IDLE),
                                  dio_s, dio_value, dio_dir, pd_mode_b, pd_mode_a,
                                  update_mask, clear_code, chain_enable};
        REG_INPUT:  next_rdata = {input_b, input_a};
        REG_DAC:    next_rdata = {dac_b, dac_a};
        default:    next_rdata = 32'h0000_0000;
      endcase
    end
    if (ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
      next_frame_enable = wb_dat_i[CTRL_FRAME_ENABLE];
      next_soft_update  = wb_dat_i[CTRL_SOFT_UPDATE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack          <= 1'b0;
      rdata        <= 32'h0000_0000;
      frame_enable <= ENABLE_RESET;
      soft_update  <= 1'b0;
    end else begin
      ack          <= next_ack;
      rdata        <= next_rdata;
      frame_enable <= next_frame_enable;
      soft_update  <= next_soft_update;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Segment and ladder drive
  always_comb begin
    next_seg_a    = therm(dac_a[CODE_MSB:SEG_LSB]); // [RULE22]
    next_seg_b    = therm(dac_b[CODE_MSB:SEG_LSB]); // [RULE22]
    next_ladder_a = dac_a[SEG_LSB-1:0]; // [RULE22]
    next_ladder_b = dac_b[SEG_LSB-1:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seg_a    <= 15'h0000;
      seg_b    <= 15'h0000;
      ladder_a <= 12'h000;
      ladder_b <= 12'h000;
    end else begin
      seg_a    <= next_seg_a;
      seg_b    <= next_seg_b;
      ladder_a <= next_ladder_a;
      ladder_b <= next_ladder_b;
    end
  end

  assign serial_out_o    = serial_out;
  assign digital_io_o    = dio_value;
  assign digital_io_oe_o = dio_dir;
  assign dac_a_o         = dac_a;
  assign dac_b_o         = dac_b;
  assign seg_a_o         = seg_a;
  assign seg_b_o         = seg_b;
  assign ladder_a_o      = ladder_a;
  assign ladder_b_o      = ladder_b;
  assign pd_mode_a_o     = pd_mode_a;
  assign pd_mode_b_o     = pd_mode_b;
  assign clear_code_o    = clear_code;
  assign update_mask_o   = update_mask;
  assign chain_enable_o  = chain_enable;
  assign wb_dat_o        = rdata;
  assign wb_ack_o        = ack;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_shift_fall;
    state == FR_SHIFT && !sync_rise && sclk_fall;
  endsequence
  sequence s_last_fall;
    s_shift_fall and count == LAST_BIT_COUNT;
  endsequence

  AST_SHIFT_IN: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
    s_shift_fall |=> shift == {$past(shift[30:0]), $past(din_s)})
    else $error("shift register did not take the data bit");
  AST_EXEC_AT_32: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
    s_last_fall and !chain_enable |-> exec_now ##1 state == FR_HOLD)
    else $error("frame not executed at last falling edge");
  AST_ABORT_DISCARD: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
    state == FR_SHIFT && sync_rise && !full |-> !exec_now ##1
    (shift == 32'h0000_0000 && state == FR_IDLE && $stable(dac_a) && $stable(chain_enable)))
    else $error("short frame was not discarded");
  AST_CMD_WRITE_INPUT: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    exec_now && cmd == CMD_WRITE_INPUT && addr == ADDR_CH_A && !soft_update |=>
    input_a == $past(frame_data) && $stable(dac_a))
    else $error("input write went wrong");
  AST_CMD_UPDATE: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    exec_now && cmd == CMD_UPDATE_DAC && sel_a |=> dac_a == $past(input_a))
    else $error("DAC update did not copy input register");
  AST_CMD_UPDATE_ALL: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
    exec_now && cmd == CMD_WRITE_UPDATE_ALL && addr_ok |=> dac_a == input_a && dac_b == input_b)
    else $error("update-all left a channel behind");
  AST_CMD_WRITE_UPDATE: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
    exec_now && cmd == CMD_WRITE_UPDATE && addr == ADDR_CH_A |=>
    dac_a == $past(frame_data) && input_a == dac_a)
    else $error("write and update failed");
  AST_POWER_MODE: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE23]
    exec_now && cmd == CMD_POWER && exec_word[FRAME_BIT_0] |=>
    pd_mode_a == $past(exec_word[PD_MODE_HI:PD_MODE_LO]))
    else $error("power mode not applied");
  AST_RESERVED: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE25]
    exec_now && !soft_update && (cmd == CMD_RESERVED || (cmd <= CMD_WRITE_UPDATE && !addr_ok))
    |=> $stable(input_a) && $stable(dac_b) && $stable(chain_enable) && $stable(pd_mode_a))
    else $error("reserved frame changed state");
  AST_CHAIN_SETUP: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE14]
    exec_now && cmd == CMD_CHAIN |=> chain_enable == $past(exec_word[FRAME_BIT_1]))
    else $error("chain enable not taken from frame bit 1");
  AST_CHAIN_RESET: assert property (@(posedge clk_i) // [RULE15]
    rst_i |=> chain_enable == 1'b0)
    else $error("chain enable not cleared by reset");
  AST_SDO_QUIET: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE26]
    !chain_enable |=> !serial_out_o)
    else $error("serial out driven in standalone mode");
  AST_THERMO: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE22]
    1'b1 |=> $countones(seg_a_o) == int'($past(dac_a[CODE_MSB:SEG_LSB])))
    else $error("segment count does not match code");

endmodule

// *** testbench/frame_host.sv ***
// Host model sending gated serial frames and sampling the chain output
`timescale 1ns/100ps
module frame_host (
  input  wire logic clk_i,
  input  wire logic serial_i,
  output logic      sclk_o,
  output logic      sync_n_o,
  output logic      din_o
);
  logic [31:0] seen;
  initial begin
    sclk_o = 1'b1;
    sync_n_o = 1'b1;
    din_o = 1'b0;
    seen = 32'h0000_0000;
  end
  // Sends the top n bits of word, then raises frame sync unless parking it low
  task automatic send(input logic [63:0] word, input int n, input logic park);
    sync_n_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    sync_n_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge clk_i);
      sclk_o <= 1'b1;
      din_o <= word[63-i];
      repeat (8) @(posedge clk_i);
      seen <= {seen[30:0], serial_i};
      sclk_o <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
    sclk_o <= 1'b1;
    din_o <= ~din_o;
    repeat (8) @(posedge clk_i);
    if (!park) sync_n_o <= 1'b1;
  endtask
endmodule

// *** testbench/dual_dac_serial_command_port_tb.sv ***
// Self-checking bench for the dual DAC serial command port
`timescale 1ns/100ps
module dual_dac_serial_command_port_tb;
  import dac_port_pkg::*;
  logic        clk, rst, sclk, sync_n, din, ser, pin, digital_io, dio_oe, chain, cyc, stb, we, ack;
  logic [15:0] dac_a, dac_b;
  logic [14:0] seg_a, seg_b;
  logic [11:0] lad_a, lad_b;
  logic [1:0]  pd_a, pd_b, clr, mask;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  int          errors = 0;
  int          n_tests = 0;
  dual_dac_serial_command_port i_dual_dac_serial_command_port (.clk_i(clk), .rst_i(rst),
    .sclk_i(sclk), .sync_n_i(sync_n), .din_i(din), .digital_io_i(pin), .serial_out_o(ser),
    .digital_io_o(digital_io), .digital_io_oe_o(dio_oe), .dac_a_o(dac_a), .dac_b_o(dac_b),
    .seg_a_o(seg_a), .seg_b_o(seg_b), .ladder_a_o(lad_a), .ladder_b_o(lad_b),
    .pd_mode_a_o(pd_a), .pd_mode_b_o(pd_b), .clear_code_o(clr), .update_mask_o(mask),
    .chain_enable_o(chain), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  frame_host i_frame_host (.clk_i(clk), .serial_i(ser), .sclk_o(sclk), .sync_n_o(sync_n),
    .din_o(din));
  initial clk = 1'b0;
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && t < 20) begin
      @(posedge clk);
      t++;
    end
    if (t == 20) errors++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] fw(input logic [3:0] c, input logic [3:0] a,
                                     input logic [15:0] d);
    return {4'h0, c, a, d, 4'h0};
  endfunction
  task automatic frame(input logic [31:0] w);
    i_frame_host.send({w, 32'h0000_0000}, 32, 1'b0);
    repeat (10) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_write();
    i_frame_host.send({fw(CMD_WRITE_INPUT, ADDR_CH_A, 16'h1234), 32'h0000_0000}, 32, 1'b1);
    repeat (10) @(posedge clk);
    check(32'(dac_a), 32'h0000_0000);
    frame(fw(CMD_UPDATE_DAC, ADDR_CH_A, 16'h0000));
    check(32'(dac_a), 32'h0000_1234);
    check(32'({seg_a, lad_a}), 32'h0000_1234);
    wb(1'b0, REG_DAC, 32'h0000_0000);
    check(q, 32'h0000_1234);
    wb(1'b1, 8'h40, 32'h0000_ffff);
    wb(1'b0, 8'h40, 32'h0000_0000);
    check(q, 32'h0000_0000);
  endtask
  task automatic t_all();
    frame(fw(CMD_WRITE_INPUT, ADDR_CH_B, 16'habcd));
    frame(fw(CMD_WRITE_UPDATE_ALL, ADDR_CH_A, 16'h5555));
    check({dac_b, dac_a}, 32'habcd_5555);
    frame(fw(CMD_WRITE_UPDATE, ADDR_CH_B, 16'hffff));
    check({dac_b, dac_a}, 32'hffff_5555);
    check(32'({seg_b, lad_b}), 32'h07ff_ffff);
    frame(fw(CMD_WRITE_UPDATE, ADDR_ALL, 16'h0f0f));
    check({dac_b, dac_a}, 32'h0f0f_0f0f);
  endtask
  task automatic t_refuse();
    i_frame_host.send({fw(CMD_WRITE_UPDATE, ADDR_CH_A, 16'h9999), 32'h0000_0000}, 20, 1'b0);
    repeat (10) @(posedge clk);
    check({dac_b, dac_a}, 32'h0f0f_0f0f);
    frame(fw(CMD_RESERVED, ADDR_CH_A, 16'h9999));
    frame(fw(CMD_WRITE_UPDATE, 4'h2, 16'h9999));
    frame(fw(CMD_WRITE_UPDATE, 4'h3, 16'h9999));
    check({dac_b, dac_a}, 32'h0f0f_0f0f);
    frame(fw(CMD_WRITE_UPDATE, ADDR_CH_A, 16'h0101));
    check({dac_b, dac_a}, 32'h0f0f_0101);
  endtask
  task automatic t_modes();
    frame(32'h0400_0201);
    check(32'({pd_b, pd_a}), 32'h0000_0002);
    frame(32'h0400_0302);
    check(32'({pd_b, pd_a}), 32'h0000_000e);
    frame(32'h0500_0002);
    frame(32'h0600_0003);
    frame(32'h0900_0003);
    check(32'({clr, mask, dio_oe, digital_io}), 32'h0000_002f);
    frame(fw(CMD_WRITE_INPUT, ADDR_CH_A, 16'h2222));
    wb(1'b1, REG_CTRL, 32'h0000_0003);
    repeat (2) @(posedge clk);
    check({dac_b, dac_a}, 32'h0f0f_2222);
    wb(1'b0, REG_INPUT, 32'h0000_0000);
    check(q, 32'h0f0f_2222);
    frame(fw(CMD_SOFT_RESET, ADDR_CH_A, 16'h0000));
    check(32'({pd_b, pd_a, clr, mask}), 32'h0000_0000);
    check({dac_b, dac_a}, 32'h0000_0000);
  endtask
  task automatic t_chain();
    frame(32'h0800_0002);
    check(32'(chain), 32'h0000_0001);
    i_frame_host.send({fw(CMD_WRITE_UPDATE, ADDR_CH_A, 16'h4321),
                       fw(CMD_WRITE_UPDATE, ADDR_CH_B, 16'h8765)}, 64, 1'b0);
    repeat (10) @(posedge clk);
    check({dac_b, dac_a}, 32'h8765_0000);
    check(i_frame_host.seen, fw(CMD_WRITE_UPDATE, ADDR_CH_A, 16'h4321));
    frame(32'h0800_0000);
    check(32'({chain, ser}), 32'h0000_0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    pin = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0000_0000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    check(32'({chain, ser, dac_a}), 32'h0000_0000);
    t_write();
    t_all();
    t_refuse();
    t_modes();
    t_chain();
    conclude();
  end
  initial begin
    #200000;
    errors++;
    conclude();
  end
endmodule
